// ### measurement_initiation_control.v
// What this block does
// [R1] With continuous run off, start nothing until enabled or single start.
// [R2] Enabling continuous run starts one; each completion launches the next.
// [R3] Powers up with continuous run on; reset command turns it off.
// [R4] Continuous enable clears statistics, zeroes count, flags not-computing bit 8.
// [R5] With limit auto-clear, enable or single start clears limit state.
// [R6] Auto trigger level runs at commands and each continuous cycle start.
// [R7] Continuous run ignores block-count auto; acts as trigger count one.
// [R8] First continuous measurement sets pending; abort or final finish clears it.
// [R9] Abort in continuous run restarts while enable stays set.
// [R10] Enable during single measurement is ignored and raises error -213.
// [R11] Disable during single measurement raises error -210.
// [R12] Stop-on-fail with limit testing clears continuous run on failure.
// [R13] Single start runs one measurement unless block conditions hold.
// [R14] Single start runs a full block with auto count, statistics, normal function.
// [R15] Block single start first clears statistics results and count.
// [R16] Single start while busy or continuous only raises error -213.
// [R17] Single start sets pending; finishing or abort clears it.
// [R18] Controller must abort an armed totalize started by single start.
// [R19] Bus trigger while listening performs the defined trigger action.
// [R20] Abort of a single measurement returns to idle without restarting.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "meas_init_defs.vh"
module measurement_initiation_control (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    input wire get_in,
    input wire listen_in,
    input wire meas_done_in,
    input wire block_done_in,
    input wire limit_fail_in,
    output reg meas_start_out,
    output reg meas_abort_out,
    output reg block_mode_out,
    output reg stats_clear_out,
    output reg limit_clear_out,
    output reg auto_trigger_out,
    output reg limit_detect_in_limit_out,
    output reg limit_indicator_off_out,
    output reg pending_op_out,
    output reg error_pulse_out,
    output reg [15:0] error_code_out
);
    localparam ST_IDLE = 2'b00;
    localparam ST_SINGLE = 2'b01;
    localparam ST_CONT = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg continuous_run_enable;
    reg stop_on_limit_fail;
    reg block_count_auto;
    reg statistics_enable;
    reg limit_test_enable;
    reg limit_auto_clear;
    reg auto_trigger_level_enable;
    reg [2:0] measurement_function_select;
    reg [2:0] trigger_action_definition;
    reg not_stats;
    reg block_run;
    reg [15:0] last_error;
    reg fail_seen;
    wire fail_sync;
    wire cont_on;
    wire cont_off;
    wire single_start_cmd;
    wire abort_cmd;
    wire reset_cmd;
    wire busy;
    wire want_block;
    wire run_done;
    wire fail_stop;

    // Totalize and voltage-peak functions never run as blocks
    function is_single_func;
        input [2:0] f;
        begin
            is_single_func = (f == `FUNC_TOTALIZE) || (f == `FUNC_VPEAK_MAX)
                || (f == `FUNC_VPEAK_MIN) || (f == `FUNC_VPEAK_PP);
        end
    endfunction

    cmd_decode u_decode (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .wr_in(wr_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .get_in(get_in),
        .listen_in(listen_in),
        .trig_action_in(trigger_action_definition),
        .cont_on_out(cont_on),
        .cont_off_out(cont_off),
        .single_out(single_start_cmd),
        .abort_out(abort_cmd),
        .reset_out(reset_cmd)
    );

    // The limit failure comes from the front-end clock domain
    gate_sync u_fail_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in(limit_fail_in),
        .q_out(fail_sync)
    );

    assign busy = (state != ST_IDLE);
    assign want_block = block_count_auto && statistics_enable
        && !is_single_func(measurement_function_select); // [R13] [R14]
    // A block run finishes on the block strobe, a single one on the measurement
    assign run_done = block_run ? block_done_in : meas_done_in;
    // Rising edge of the synchronised failure level
    assign fail_stop = fail_sync && !fail_seen && stop_on_limit_fail
        && limit_test_enable && continuous_run_enable; // [R12]

    // Configuration writes; reset command restores defaults
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stop_on_limit_fail <= 1'b0;
            block_count_auto <= 1'b0;
            statistics_enable <= 1'b0;
            limit_test_enable <= 1'b0;
            limit_auto_clear <= 1'b0;
            auto_trigger_level_enable <= 1'b0;
            measurement_function_select <= 3'h0;
            trigger_action_definition <= `TRIG_ACTION_RESET;
        end
        else if (reset_cmd)
        begin
            stop_on_limit_fail <= 1'b0; // [R12]
            block_count_auto <= 1'b0;
            statistics_enable <= 1'b0;
            limit_test_enable <= 1'b0;
            limit_auto_clear <= 1'b0;
            auto_trigger_level_enable <= 1'b0;
            measurement_function_select <= 3'h0;
            trigger_action_definition <= `TRIG_ACTION_RESET;
        end
        else if (wr_in && addr_in == `REG_CTRL)
        begin
            stop_on_limit_fail <= wdata_in[`CTRL_STOP_ON_FAIL];
            block_count_auto <= wdata_in[`CTRL_BLOCK_AUTO];
            statistics_enable <= wdata_in[`CTRL_STATS_EN];
            limit_test_enable <= wdata_in[`CTRL_LIMIT_TEST];
            limit_auto_clear <= wdata_in[`CTRL_LIMIT_AUTO_CLR];
            auto_trigger_level_enable <= wdata_in[`CTRL_AUTO_TRIG_LVL];
            measurement_function_select <= wdata_in[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
        end
        else if (wr_in && addr_in == `REG_TRIG_ACTION)
        begin
            trigger_action_definition <= wdata_in[2:0];
        end
    end

    // Sequencer next state
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cont_on && continuous_run_enable == 1'b0)
                    next_state = ST_CONT; // [R2]
                else if (continuous_run_enable && !reset_cmd)
                    next_state = ST_CONT; // power-up enable starts running
                else if (single_start_cmd)
                    next_state = ST_SINGLE; // [R1]
            end
            ST_SINGLE:
            begin
                if (abort_cmd || run_done)
                    next_state = ST_IDLE; // [R17] [R20]
            end
            ST_CONT:
            begin
                if ((meas_done_in || abort_cmd) && !continuous_run_enable)
                    next_state = ST_IDLE; // [R8]
                else if (reset_cmd && abort_cmd)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Sequencer, run enable, pending flag and command side effects
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            continuous_run_enable <= `POWERUP_CONT; // [R3]
            pending_op_out <= 1'b0;
            block_run <= 1'b0;
            not_stats <= 1'b0;
            fail_seen <= 1'b0;
            meas_start_out <= 1'b0;
            meas_abort_out <= 1'b0;
            block_mode_out <= 1'b0;
            stats_clear_out <= 1'b0;
            limit_clear_out <= 1'b0;
            auto_trigger_out <= 1'b0;
            limit_detect_in_limit_out <= 1'b1;
            limit_indicator_off_out <= 1'b0;
            error_pulse_out <= 1'b0;
            error_code_out <= `ERR_NONE;
            last_error <= `ERR_NONE;
        end
        else
        begin
            state <= next_state;
            fail_seen <= fail_sync;
            meas_start_out <= 1'b0;
            meas_abort_out <= abort_cmd && busy;
            stats_clear_out <= 1'b0;
            limit_clear_out <= 1'b0;
            auto_trigger_out <= 1'b0;
            limit_indicator_off_out <= 1'b0;
            error_pulse_out <= 1'b0;
            if (reset_cmd)
                continuous_run_enable <= 1'b0; // [R3]
            else if (fail_stop)
                continuous_run_enable <= 1'b0; // [R12]
            else if (cont_off)
                continuous_run_enable <= 1'b0;
            else if (cont_on && state != ST_SINGLE)
                continuous_run_enable <= 1'b1;
            // Enable while a single run is active is refused
            if (cont_on && state == ST_SINGLE)
            begin
                error_pulse_out <= 1'b1; // [R10]
                error_code_out <= `ERR_INIT_IGNORED;
                last_error <= `ERR_INIT_IGNORED;
            end
            else if (cont_off && state == ST_SINGLE)
            begin
                error_pulse_out <= 1'b1; // [R11]
                error_code_out <= `ERR_TRIGGER;
                last_error <= `ERR_TRIGGER;
            end
            else if (single_start_cmd && (busy || continuous_run_enable))
            begin
                error_pulse_out <= 1'b1; // [R16]
                error_code_out <= `ERR_INIT_IGNORED;
                last_error <= `ERR_INIT_IGNORED;
            end
            // Accepted enable clears statistics and flags the not-computing bit
            if (cont_on && state != ST_SINGLE)
            begin
                stats_clear_out <= 1'b1; // [R4]
                not_stats <= 1'b1; // [R4]
            end
            else if (state != ST_CONT && !busy && single_start_cmd
                && !continuous_run_enable && statistics_enable)
                not_stats <= 1'b0;
            // Limit auto-clear on an accepted command
            if (limit_auto_clear && ((cont_on && state != ST_SINGLE)
                || (single_start_cmd && !busy && !continuous_run_enable)))
            begin
                limit_clear_out <= 1'b1; // [R5]
                limit_indicator_off_out <= 1'b1; // [R5]
                limit_detect_in_limit_out <= 1'b1; // [R5]
            end
            else if (fail_sync && limit_test_enable)
                limit_detect_in_limit_out <= 1'b0;
            // Launch on entry to a running state
            if (state == ST_IDLE && next_state == ST_SINGLE)
            begin
                meas_start_out <= 1'b1;
                block_run <= want_block; // [R14]
                block_mode_out <= want_block; // [R13]
                pending_op_out <= 1'b1; // [R17]
                if (want_block)
                    stats_clear_out <= 1'b1; // [R15]
                if (auto_trigger_level_enable)
                    auto_trigger_out <= 1'b1; // [R6]
            end
            else if (state == ST_IDLE && next_state == ST_CONT)
            begin
                meas_start_out <= 1'b1; // [R2]
                block_run <= 1'b0;
                block_mode_out <= 1'b0; // [R7]
                pending_op_out <= 1'b1; // [R8]
                if (auto_trigger_level_enable)
                    auto_trigger_out <= 1'b1; // [R6]
            end
            else if (state == ST_CONT && next_state == ST_CONT
                && (meas_done_in || abort_cmd))
            begin
                meas_start_out <= 1'b1; // [R2] [R9]
                if (abort_cmd)
                    pending_op_out <= 1'b0; // [R8]
                if (auto_trigger_level_enable)
                    auto_trigger_out <= 1'b1; // [R6]
            end
            else if (busy && next_state == ST_IDLE)
            begin
                pending_op_out <= 1'b0; // [R8] [R17]
                block_run <= 1'b0;
                block_mode_out <= 1'b0;
            end
            else if (state == ST_CONT && meas_start_out)
                pending_op_out <= 1'b1;
        end
    end

    // Register read port: data stand in the cycle after the strobe
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            case (addr_in)
                `REG_CTRL: rdata_out <= {5'h00, measurement_function_select, 2'h0,
                    auto_trigger_level_enable, limit_auto_clear, limit_test_enable,
                    statistics_enable, block_count_auto, stop_on_limit_fail};
                `REG_STATUS: rdata_out <= {7'h00, not_stats, 4'h0, block_run,
                    busy, pending_op_out, continuous_run_enable};
                `REG_ERROR: rdata_out <= last_error;
                `REG_TRIG_ACTION: rdata_out <= {13'h0000, trigger_action_definition};
                default: rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end
endmodule

// ### meas_init_defs.vh
`ifndef MEAS_INIT_DEFS_VH
`define MEAS_INIT_DEFS_VH
// Register offsets (word addresses on the plain register port)
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_STATUS 4'h2
`define REG_ERROR 4'h3
`define REG_TRIG_ACTION 4'h4
// Control register field positions
`define CTRL_STOP_ON_FAIL 0
`define CTRL_BLOCK_AUTO 1
`define CTRL_STATS_EN 2
`define CTRL_LIMIT_TEST 3
`define CTRL_LIMIT_AUTO_CLR 4
`define CTRL_AUTO_TRIG_LVL 5
`define CTRL_FUNC_LSB 8
`define CTRL_FUNC_MSB 10
// Command register field positions (write one to issue)
`define CMD_CONT_ON 0
`define CMD_CONT_OFF 1
`define CMD_SINGLE 2
`define CMD_ABORT 3
`define CMD_RESET 4
// Status register field positions
`define STAT_CONT 0
`define STAT_PENDING 1
`define STAT_BUSY 2
`define STAT_BLOCK 3
`define STAT_NOT_STATS 8
// Measurement function codes
`define FUNC_TOTALIZE 3'h5
`define FUNC_VPEAK_MAX 3'h6
`define FUNC_VPEAK_MIN 3'h7
`define FUNC_VPEAK_PP 3'h4
// Error codes (two's complement, 16 bits)
`define ERR_NONE 16'h0000
`define ERR_INIT_IGNORED 16'hFF2B
`define ERR_TRIGGER 16'hFF2E
// Reset values
`define CTRL_RESET 16'h0000
`define TRIG_ACTION_RESET 3'h4
`define POWERUP_CONT 1'b1
`endif

// ### cmd_decode.v
`timescale 1ns/100ps
`include "meas_init_defs.vh"
// Turns register writes and the bus trigger into one-cycle command pulses
module cmd_decode (
    input wire ref_clk_in,
    input wire rst_in,
    input wire wr_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire get_in,
    input wire listen_in,
    input wire [2:0] trig_action_in,
    output reg cont_on_out,
    output reg cont_off_out,
    output reg single_out,
    output reg abort_out,
    output reg reset_out
);
    wire cmd_wr;
    wire trig;
    assign cmd_wr = wr_in && (addr_in == `REG_CMD);
    // Trigger only counts while addressed as listener
    assign trig = get_in && listen_in;

    // Register the pulses so commands reach the sequencer in a fixed cycle
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cont_on_out <= 1'b0;
            cont_off_out <= 1'b0;
            single_out <= 1'b0;
            abort_out <= 1'b0;
            reset_out <= 1'b0;
        end
        else
        begin
            cont_on_out <= (cmd_wr && wdata_in[`CMD_CONT_ON])
                || (trig && trig_action_in[`CMD_CONT_ON]); // [R19]
            cont_off_out <= (cmd_wr && wdata_in[`CMD_CONT_OFF])
                || (trig && trig_action_in[`CMD_CONT_OFF]); // [R19]
            single_out <= (cmd_wr && wdata_in[`CMD_SINGLE])
                || (trig && trig_action_in[`CMD_SINGLE]); // [R19]
            abort_out <= cmd_wr && wdata_in[`CMD_ABORT];
            reset_out <= cmd_wr && wdata_in[`CMD_RESET];
        end
    end
endmodule

// ### gate_sync.v
`timescale 1ns/100ps
// Three-stage synchroniser; output changes once stages two and three agree
module gate_sync (
    input wire ref_clk_in,
    input wire rst_in,
    input wire d_in,
    output reg q_out
);
    reg s1;
    reg s2;
    reg s3;

    // Stage one is read only by stage two to keep metastability contained
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q_out <= 1'b0;
        end
        else
        begin
            s1 <= d_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                q_out <= s3;
        end
    end
endmodule

// ### meas_init_chk_sva.sv
`timescale 1ns/100ps
`include "meas_init_defs.vh"
module meas_init_chk (
    input wire ref_clk_in,
    input wire rst_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire get_in,
    input wire listen_in,
    input wire meas_done_in,
    input wire block_done_in,
    input wire meas_start_out,
    input wire meas_abort_out,
    input wire block_mode_out,
    input wire stats_clear_out,
    input wire limit_clear_out,
    input wire auto_trigger_out,
    input wire limit_detect_in_limit_out,
    input wire limit_indicator_off_out,
    input wire pending_op_out,
    input wire error_pulse_out,
    input wire [15:0] error_code_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    reg [15:0] ctrl;
    // Shadow of the control word so single-start outcomes can be predicted
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            ctrl <= `CTRL_RESET;
        else if (wr_in && addr_in == `REG_CTRL)
            ctrl <= wdata_in;
    end
    // Idle command write; a completion in flight could race the decode
    wire cmd_wr = wr_in && addr_in == `REG_CMD && !pending_op_out && !meas_done_in &&
        !block_done_in;
    wire blk = ctrl[1] && ctrl[2] && ctrl[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] < 3'h4;
    wire busy_single = wr_in && addr_in == `REG_CMD && wdata_in == 16'h0004 && pending_op_out
        && !meas_done_in && !block_done_in;
    wire start_wr = cmd_wr && wdata_in inside {16'h0001, 16'h0004};
    cont_launch_a: assert property (cmd_wr && wdata_in == 16'h0001 |-> ##2
        meas_start_out && pending_op_out && stats_clear_out) else $error("cont on launch");
    single_one_a: assert property (cmd_wr && wdata_in == 16'h0004 && !blk |-> ##2
        meas_start_out && pending_op_out && !block_mode_out) else $error("single start");
    single_block_a: assert property (cmd_wr && wdata_in == 16'h0004 && blk |-> ##2
        meas_start_out && block_mode_out && stats_clear_out) else $error("block start");
    limit_clear_a: assert property (start_wr && ctrl[4]
        |-> ##2 limit_clear_out && limit_indicator_off_out && limit_detect_in_limit_out)
        else $error("limit clear");
    auto_trig_a: assert property (start_wr && ctrl[5]
        |-> ##2 auto_trigger_out) else $error("auto trigger");
    busy_refuse_a: assert property (busy_single |-> ##2 error_pulse_out
        && error_code_out == `ERR_INIT_IGNORED) else $error("busy single");
    start_pending_a: assert property (meas_start_out |-> pending_op_out != meas_abort_out)
        else $error("start without pending");
    // Only valid while the trigger action keeps its reset value
    get_action_a: assert property (get_in && listen_in && !wr_in && !pending_op_out |->
        ##2 meas_start_out) else $error("bus trigger");
    abort_pulse_a: assert property (meas_abort_out |=> !meas_abort_out)
        else $error("abort pulse");
endmodule
bind measurement_initiation_control meas_init_chk chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .get_in(get_in),
    .listen_in(listen_in), .meas_done_in(meas_done_in), .block_done_in(block_done_in),
    .meas_start_out(meas_start_out), .meas_abort_out(meas_abort_out),
    .block_mode_out(block_mode_out), .stats_clear_out(stats_clear_out),
    .limit_clear_out(limit_clear_out), .auto_trigger_out(auto_trigger_out),
    .limit_detect_in_limit_out(limit_detect_in_limit_out),
    .limit_indicator_off_out(limit_indicator_off_out), .pending_op_out(pending_op_out),
    .error_pulse_out(error_pulse_out), .error_code_out(error_code_out));

// ### meas_engine_model.sv
`timescale 1ns/100ps
module meas_engine_model (
    input wire ref_clk_in,
    input wire rst_in,
    input wire start_in,
    input wire abort_in,
    input wire block_in,
    input wire [7:0] delay_in,
    output reg done_out,
    output reg block_done_out
);
    reg [7:0] left;
    // Delay zero models an armed totalize that only an abort ends
    always @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            left <= 8'h00;
            done_out <= 1'h0;
            block_done_out <= 1'h0;
        end
        else
        begin
            done_out <= !block_in && left == 8'h01;
            block_done_out <= block_in && left == 8'h01;
            if (start_in)
                left <= delay_in;
            else if (abort_in || left == 8'h01)
                left <= 8'h00;
            else if (left > 8'h01)
                left <= left - 8'h01;
        end
    end
endmodule

// ### measurement_initiation_control_tb.sv
`timescale 1ns/100ps
`include "meas_init_defs.vh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module measurement_initiation_control_tb;
    logic ref_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'h0, rd_in = 1'h0, get_in = 1'h0, listen_in = 1'h0, limit_fail_in = 1'h0;
    logic [7:0] dly = 8'h05;
    logic [15:0] rdv;
    wire [15:0] rdata_out, error_code_out;
    wire meas_done_in, block_done_in, meas_start_out, meas_abort_out, block_mode_out;
    wire stats_clear_out, limit_clear_out, auto_trigger_out, limit_detect_in_limit_out;
    wire limit_indicator_off_out, pending_op_out, error_pulse_out;
    wire lim_clr = &{limit_clear_out, limit_indicator_off_out, limit_detect_in_limit_out};
    // Rows: control word, then expected block, stats clear, limit clear, auto trigger
    logic [19:0] rows [0:11] = '{20'h0006C, 20'h0106C, 20'h0206C, 20'h0306C, 20'h04060,
        20'h05060, 20'h06060, 20'h07060, 20'h00020, 20'h00040, 20'h00102, 20'h00201};
    integer error_cnt = 0, compares = 0, cyc = 0, j;
    measurement_initiation_control DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .get_in(get_in), .listen_in(listen_in),
        .meas_done_in(meas_done_in), .block_done_in(block_done_in),
        .limit_fail_in(limit_fail_in), .meas_start_out(meas_start_out),
        .meas_abort_out(meas_abort_out), .block_mode_out(block_mode_out),
        .stats_clear_out(stats_clear_out), .limit_clear_out(limit_clear_out),
        .auto_trigger_out(auto_trigger_out),
        .limit_detect_in_limit_out(limit_detect_in_limit_out),
        .limit_indicator_off_out(limit_indicator_off_out), .pending_op_out(pending_op_out),
        .error_pulse_out(error_pulse_out), .error_code_out(error_code_out));
    meas_engine_model eng (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .start_in(meas_start_out), .abort_in(meas_abort_out), .block_in(block_mode_out),
        .delay_in(dly), .done_out(meas_done_in), .block_done_out(block_done_in));
    // Free-running instrument clock
    initial
    begin
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    task wrap_up;
        begin
            $display("compares %0d error_cnt %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Hang guard, sized well above the whole sequence
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("[ERR] %0t run timed out", $time);
            wrap_up;
        end
    end
    task step;
        begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    // Bus cycles: strobes last one cycle and change just after an edge
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge ref_clk_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'h1;
            @(posedge ref_clk_in);
            wr_in <= 1'h0;
        end
    endtask
    task rd(input [3:0] a);
        begin
            @(posedge ref_clk_in);
            addr_in <= a;
            rd_in <= 1'h1;
            @(posedge ref_clk_in);
            rd_in <= 1'h0;
            #1 rdv = rdata_out;
        end
    endtask
    task get_pulse(input l);
        begin
            @(posedge ref_clk_in);
            get_in <= 1'h1;
            listen_in <= l;
            @(posedge ref_clk_in);
            get_in <= 1'h0;
            step;
        end
    endtask
    task wait_idle;
        integer k;
        begin
            for (k = 0; k < 600 && pending_op_out !== 1'h0; k++)
                step;
        end
    endtask
    task wait_done;
        integer k;
        begin
            for (k = 0; k < 50 && meas_done_in !== 1'h1; k++)
                step;
        end
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        repeat (3) step;
        `CHK(pending_op_out, 1'h1)
        rd(`REG_STATUS);
        `CHK(rdv[`STAT_CONT], 1'h1)
        wr(`REG_CMD, 16'h0010);
        wait_idle;
        `CHK(pending_op_out, 1'h0)
        rd(`REG_STATUS);
        `CHK(rdv[`STAT_CONT], 1'h0)
        rd(4'hF);
        `CHK({rdv, meas_start_out}, 17'h00000)
        dly <= 8'h03;
        for (j = 0; j < 12; j++)
        begin
            wr(`REG_CTRL, rows[j][19:4]);
            wr(`REG_CMD, 16'h0004);
            step;
            `CHK({meas_start_out, pending_op_out}, 2'h3)
            `CHK(block_mode_out, rows[j][3])
            `CHK(stats_clear_out | ~rows[j][2], 1'h1)
            `CHK(lim_clr | ~rows[j][1], 1'h1)
            `CHK(auto_trigger_out | ~rows[j][0], 1'h1)
            wait_idle;
            `CHK(pending_op_out, 1'h0)
        end
        // Armed totalize: refusals while it runs, then the controller aborts it
        dly <= 8'h00;
        wr(`REG_CTRL, 16'h0500);
        wr(`REG_CMD, 16'h0004);
        wr(`REG_CMD, 16'h0004);
        step;
        `CHK({error_pulse_out, error_code_out}, {1'h1, `ERR_INIT_IGNORED})
        wr(`REG_CMD, 16'h0001);
        step;
        `CHK({error_pulse_out, error_code_out}, {1'h1, `ERR_INIT_IGNORED})
        rd(`REG_STATUS);
        `CHK(rdv[`STAT_CONT], 1'h0)
        wr(`REG_CMD, 16'h0002);
        step;
        `CHK({error_pulse_out, error_code_out}, {1'h1, `ERR_TRIGGER})
        wr(`REG_CMD, 16'h0008);
        wait_idle;
        repeat (8) step;
        `CHK(pending_op_out, 1'h0)
        dly <= 8'h04;
        get_pulse(1'h0);
        `CHK(meas_start_out, 1'h0)
        get_pulse(1'h1);
        `CHK(meas_start_out, 1'h1)
        wait_idle;
        // Continuous run with block settings that it must ignore
        wr(`REG_CTRL, 16'h0006);
        wr(`REG_CMD, 16'h0001);
        step;
        `CHK({meas_start_out, block_mode_out, stats_clear_out}, 3'h5)
        rd(`REG_STATUS);
        `CHK({rdv[`STAT_NOT_STATS], rdv[`STAT_CONT]}, 2'h3)
        for (j = 0; j < 3; j++)
        begin
            wait_done;
            step;
            `CHK(meas_start_out, 1'h1)
        end
        // Endless measurements from here, so any restart must come from the abort
        dly <= 8'h00;
        wait_done;
        step;
        wr(`REG_CMD, 16'h0008);
        step;
        for (j = 0; j < 10 && meas_start_out !== 1'h1; j++)
            step;
        `CHK(meas_start_out, 1'h1)
        wr(`REG_CMD, 16'h0004);
        step;
        `CHK({error_pulse_out, error_code_out}, {1'h1, `ERR_INIT_IGNORED})
        wr(`REG_CTRL, 16'h0008);
        @(posedge ref_clk_in) limit_fail_in <= 1'h1;
        repeat (8) step;
        rd(`REG_STATUS);
        `CHK(rdv[`STAT_CONT], 1'h1)
        @(posedge ref_clk_in) limit_fail_in <= 1'h0;
        wr(`REG_CTRL, 16'h0009);
        repeat (6) step;
        @(posedge ref_clk_in) limit_fail_in <= 1'h1;
        repeat (8) step;
        rd(`REG_STATUS);
        `CHK({rdv[`STAT_CONT], pending_op_out}, 2'h1)
        wr(`REG_CMD, 16'h0008);
        wait_idle;
        `CHK(pending_op_out, 1'h0)
        wrap_up;
    end
endmodule
